//--- inc/msi_vpd_pkg.sv
/*
 * Constants, field positions, reset values and carrier types for the
 * interrupt-message and product-data capability register bank.
 * Assumes one core clock and an AXI4-Lite master issuing 32-bit accesses.
 */
// How it works
// RULE_01 - Enable bit gates messages versus legacy interrupt.
// RULE_02 - 64-bit address capable bit reads one.
// RULE_03 - Message address is dword aligned, resets zero.
// RULE_04 - Upper message address register, resets zero.
// RULE_05 - Message registers exist only on downstream ports.
// RULE_06 - Product data header identifier reads 03h.
// RULE_07 - Product data next pointer reads 64h.
// RULE_08 - Six-bit table dword address, resets zero.
// RULE_09 - Write enable bit gates table writes.
// RULE_10 - Flag zero starts read, set when done.
// RULE_11 - Flag one starts write, cleared when done.
// RULE_12 - Data register returns last fetched table word.
// RULE_13 - Written data goes into table on write.
// RULE_14 - Product data registers exist only upstream.
// RULE_15 - Vendor header identifier reads 09h.
// RULE_16 - Vendor next pointer reads B0h.
// RULE_17 - Vendor length field reads 34h.
// RULE_18 - Message capability header identifier reads 05h.
// RULE_19 - Enabled interrupt issues write with programmed data.
// RULE_20 - Software waits for flag before next access.
package msi_vpd_pkg;

	// ***********************************************************
	// Register map
	// ***********************************************************
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] OFF_MSI_CTRL = 8'h4c;
	localparam logic [7:0] OFF_MSI_ADDR = 8'h50;
	localparam logic [7:0] OFF_MSI_UADDR = 8'h54;
	localparam logic [7:0] OFF_MSI_DATA = 8'h58;
	localparam logic [7:0] OFF_VPD_CTRL = 8'h5c;
	localparam logic [7:0] OFF_PRODUCT_DATA_VALUE = 8'h60;
	localparam logic [7:0] OFF_VENDOR = 8'h64;

	// ***********************************************************
	// Capability headers
	// ***********************************************************
	localparam logic [7:0] CAP_ID_MSI = 8'h05;
	localparam logic [7:0] CAP_ID_VPD = 8'h03;
	localparam logic [7:0] CAP_ID_VENDOR = 8'h09;
	localparam logic [7:0] NEXT_PTR_VENDOR = 8'h64;
	localparam logic [7:0] NEXT_PTR_SSID = 8'hb0;
	localparam logic [15:0] VENDOR_LENGTH = 16'h0034;

	// ***********************************************************
	// Field positions
	// ***********************************************************
	localparam int MSI_EN_BIT = 16;
	localparam int MMC_LSB = 17;
	localparam int MME_LSB = 20;
	localparam int ADDR64_BIT = 23;
	localparam int VPD_ADDR_LSB = 18;
	localparam int VPD_WE_BIT = 30;
	localparam int VPD_OP_BIT = 31;

	// ***********************************************************
	// Reset and fixed values
	// ***********************************************************
	localparam logic RST_MSI_EN = 1'b0;
	localparam logic [2:0] RST_MME = 3'h0;
	localparam logic [2:0] MMC_VALUE = 3'h0;
	localparam logic ADDR64_VALUE = 1'b1;
	localparam logic [29:0] RST_MSI_ADDR = 30'h0000_0000;
	localparam logic [31:0] RST_MSI_UADDR = 32'h0000_0000;
	localparam logic [15:0] RST_MSI_DATA = 16'h0000;
	localparam logic [5:0] RST_VPD_ADDR = 6'h00;
	localparam logic RST_VPD_WE = 1'b0;
	localparam logic RST_VPD_OP = 1'b0;
	localparam logic [31:0] RST_PRODUCT_DATA_VALUE = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ***********************************************************
	// Types
	// ***********************************************************
	typedef enum logic [1:0] {
		VPD_IDLE = 2'h0,
		VPD_WAIT = 2'h1
	} vpd_state_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [5:0] addr;
		logic [31:0] wdata;
	} eeprom_req_t;

	typedef struct packed {
		logic valid;
		logic [63:0] addr;
		logic [15:0] data;
	} msi_msg_t;

endpackage

//--- hw/msi_vpd_regs.sv
/*
 * Capability register bank of one switch port: interrupt-message registers on
 * downstream ports, product-data table access on the upstream port, and the
 * vendor capability header on both, reached over AXI4-Lite.
 * Assumes the table controller, the interrupt source and the bus master all
 * run on aclk, so no input here needs a synchroniser.
 */
`timescale 1ns/10ps
module msi_vpd_regs #(
	parameter bit IS_UPSTREAM = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_event,
	input wire logic irq_clear,
	output logic intx_assert,
	output msi_vpd_pkg::msi_msg_t msi_msg,
	output msi_vpd_pkg::eeprom_req_t ee_req,
	input wire logic ee_ack,
	input wire logic [31:0] ee_rdata
);

	// ***********************************************************
	// Decoding helpers
	// ***********************************************************
	function automatic logic reg_present(input logic [7:0] off);
		logic hit;
		hit = 1'b0;
		case (off)
			msi_vpd_pkg::OFF_MSI_CTRL,
			msi_vpd_pkg::OFF_MSI_ADDR,
			msi_vpd_pkg::OFF_MSI_UADDR,
			msi_vpd_pkg::OFF_MSI_DATA: hit = !IS_UPSTREAM;
			msi_vpd_pkg::OFF_VPD_CTRL,
			msi_vpd_pkg::OFF_PRODUCT_DATA_VALUE: hit = IS_UPSTREAM;
			msi_vpd_pkg::OFF_VENDOR: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ***********************************************************
	// State
	// ***********************************************************
	logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
	logic [7:0] wr_off_r, wr_off_nxt;
	logic [31:0] wr_data_r, wr_data_nxt;
	logic [3:0] wr_strb_r, wr_strb_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] rd_off_r, rd_off_nxt;
	logic do_wr;
	logic [31:0] rd_word, merged;

	logic msi_en_r, msi_en_nxt;
	logic [2:0] mme_r, mme_nxt;
	logic [29:0] msi_addr_r, msi_addr_nxt;
	logic [31:0] msi_uaddr_r, msi_uaddr_nxt;
	logic [15:0] msi_data_r, msi_data_nxt;
	logic intx_r, intx_nxt;
	msi_vpd_pkg::msi_msg_t msi_msg_r, msi_msg_nxt;

	logic [5:0] vpd_addr_r, vpd_addr_nxt;
	logic vpd_we_r, vpd_we_nxt, vpd_op_r, vpd_op_nxt;
	logic [31:0] product_data_value_r, product_data_value_nxt;
	msi_vpd_pkg::vpd_state_t vpd_state_r, vpd_state_nxt;
	msi_vpd_pkg::eeprom_req_t ee_req_r, ee_req_nxt;

	// ***********************************************************
	// Read data mux
	// ***********************************************************
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr & 8'hfc)
			msi_vpd_pkg::OFF_MSI_CTRL: begin
				rd_word[7:0] = msi_vpd_pkg::CAP_ID_MSI; // RULE_18
				rd_word[15:8] = msi_vpd_pkg::NEXT_PTR_VENDOR;
				rd_word[msi_vpd_pkg::MSI_EN_BIT] = msi_en_r;
				rd_word[msi_vpd_pkg::MMC_LSB +: 3] = msi_vpd_pkg::MMC_VALUE;
				rd_word[msi_vpd_pkg::MME_LSB +: 3] = mme_r;
				rd_word[msi_vpd_pkg::ADDR64_BIT] = msi_vpd_pkg::ADDR64_VALUE; // RULE_02
			end
			msi_vpd_pkg::OFF_MSI_ADDR: rd_word = {msi_addr_r, 2'b00}; // RULE_03
			msi_vpd_pkg::OFF_MSI_UADDR: rd_word = msi_uaddr_r; // RULE_04
			msi_vpd_pkg::OFF_MSI_DATA: rd_word[15:0] = msi_data_r;
			msi_vpd_pkg::OFF_VPD_CTRL: begin
				rd_word[7:0] = msi_vpd_pkg::CAP_ID_VPD; // RULE_06
				rd_word[15:8] = msi_vpd_pkg::NEXT_PTR_VENDOR; // RULE_07
				rd_word[msi_vpd_pkg::VPD_ADDR_LSB +: 6] = vpd_addr_r;
				rd_word[msi_vpd_pkg::VPD_WE_BIT] = vpd_we_r;
				rd_word[msi_vpd_pkg::VPD_OP_BIT] = vpd_op_r;
			end
			msi_vpd_pkg::OFF_PRODUCT_DATA_VALUE: rd_word = product_data_value_r; // RULE_12
			msi_vpd_pkg::OFF_VENDOR: begin
				rd_word[7:0] = msi_vpd_pkg::CAP_ID_VENDOR; // RULE_15
				rd_word[15:8] = msi_vpd_pkg::NEXT_PTR_SSID; // RULE_16
				rd_word[31:16] = msi_vpd_pkg::VENDOR_LENGTH; // RULE_17
			end
			default: rd_word = 32'h0000_0000;
		endcase
		if (!reg_present(s_axi_araddr & 8'hfc)) begin
			rd_word = 32'h0000_0000; // RULE_05 RULE_14
		end
	end

	// ***********************************************************
	// AXI4-Lite channels
	// ***********************************************************
	// A write commits one cycle after both halves are held, which keeps the
	// register update off the bus input paths at the cost of a cycle.
	assign do_wr = aw_full_r && w_full_r && !bvalid_r;

	always_comb begin
		aw_full_nxt = aw_full_r;
		w_full_nxt = w_full_r;
		wr_off_nxt = wr_off_r;
		wr_data_nxt = wr_data_r;
		wr_strb_nxt = wr_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		rd_off_nxt = rd_off_r;
		if (s_axi_awvalid && awready_r) begin
			aw_full_nxt = 1'b1;
			wr_off_nxt = s_axi_awaddr & 8'hfc;
		end
		if (s_axi_wvalid && wready_r) begin
			w_full_nxt = 1'b1;
			wr_data_nxt = s_axi_wdata;
			wr_strb_nxt = s_axi_wstrb;
		end
		if (do_wr) begin
			aw_full_nxt = 1'b0;
			w_full_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = reg_present(wr_off_r) ? msi_vpd_pkg::RESP_OKAY
				: msi_vpd_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rd_off_nxt = s_axi_araddr & 8'hfc;
			rresp_nxt = reg_present(s_axi_araddr & 8'hfc) ? msi_vpd_pkg::RESP_OKAY
				: msi_vpd_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		awready_nxt = !aw_full_nxt && !bvalid_nxt;
		wready_nxt = !w_full_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			wr_off_r <= 8'h00;
			wr_data_r <= 32'h0000_0000;
			wr_strb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= msi_vpd_pkg::RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= msi_vpd_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			rd_off_r <= 8'h00;
		end else if (ce) begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			wr_off_r <= wr_off_nxt;
			wr_data_r <= wr_data_nxt;
			wr_strb_r <= wr_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			rd_off_r <= rd_off_nxt;
		end
	end

	// ***********************************************************
	// Register writes, table handshake and interrupt signalling
	// ***********************************************************
	always_comb begin
		msi_en_nxt = msi_en_r;
		mme_nxt = mme_r;
		msi_addr_nxt = msi_addr_r;
		msi_uaddr_nxt = msi_uaddr_r;
		msi_data_nxt = msi_data_r;
		vpd_addr_nxt = vpd_addr_r;
		vpd_we_nxt = vpd_we_r;
		vpd_op_nxt = vpd_op_r;
		product_data_value_nxt = product_data_value_r;
		vpd_state_nxt = vpd_state_r;
		ee_req_nxt = ee_req_r;
		merged = 32'h0000_0000;
		if (do_wr && reg_present(wr_off_r)) begin
			case (wr_off_r)
				msi_vpd_pkg::OFF_MSI_CTRL: begin
					if (wr_strb_r[2]) begin
						msi_en_nxt = wr_data_r[msi_vpd_pkg::MSI_EN_BIT];
						mme_nxt = wr_data_r[msi_vpd_pkg::MME_LSB +: 3];
					end
				end
				msi_vpd_pkg::OFF_MSI_ADDR: begin
					merged = merge({msi_addr_r, 2'b00}, wr_data_r, wr_strb_r);
					msi_addr_nxt = merged[31:2]; // RULE_03
				end
				msi_vpd_pkg::OFF_MSI_UADDR: begin
					msi_uaddr_nxt = merge(msi_uaddr_r, wr_data_r, wr_strb_r); // RULE_04
				end
				msi_vpd_pkg::OFF_MSI_DATA: begin
					merged = merge({16'h0000, msi_data_r}, wr_data_r, wr_strb_r);
					msi_data_nxt = merged[15:0];
				end
				// Table registers are frozen while a cycle is in flight.
				msi_vpd_pkg::OFF_VPD_CTRL: begin
					if (vpd_state_r == msi_vpd_pkg::VPD_IDLE) begin
						if (wr_strb_r[2]) begin
							vpd_addr_nxt = wr_data_r[msi_vpd_pkg::VPD_ADDR_LSB +: 6]; // RULE_08
						end
						if (wr_strb_r[3]) begin
							vpd_we_nxt = wr_data_r[msi_vpd_pkg::VPD_WE_BIT];
							vpd_op_nxt = wr_data_r[msi_vpd_pkg::VPD_OP_BIT];
							if (vpd_op_nxt && !vpd_we_nxt) begin
								vpd_op_nxt = 1'b0; // RULE_09
							end else begin
								vpd_state_nxt = msi_vpd_pkg::VPD_WAIT; // RULE_10
								ee_req_nxt.req = 1'b1;
								ee_req_nxt.write = vpd_op_nxt; // RULE_11
								ee_req_nxt.addr = vpd_addr_nxt;
								ee_req_nxt.wdata = product_data_value_r; // RULE_13
							end
						end
					end
				end
				msi_vpd_pkg::OFF_PRODUCT_DATA_VALUE: begin
					if (vpd_state_r == msi_vpd_pkg::VPD_IDLE) begin
						product_data_value_nxt = merge(product_data_value_r, wr_data_r, wr_strb_r); // RULE_13
					end
				end
				default: merged = 32'h0000_0000;
			endcase
		end
		if (vpd_state_r == msi_vpd_pkg::VPD_WAIT && ee_ack) begin
			vpd_state_nxt = msi_vpd_pkg::VPD_IDLE;
			ee_req_nxt.req = 1'b0;
			if (ee_req_r.write) begin
				vpd_op_nxt = 1'b0; // RULE_11
			end else begin
				vpd_op_nxt = 1'b1; // RULE_10
				product_data_value_nxt = ee_rdata; // RULE_12
			end
		end
		msi_msg_nxt.valid = irq_event && msi_en_r; // RULE_01 RULE_19
		msi_msg_nxt.addr = {msi_uaddr_r, msi_addr_r, 2'b00};
		msi_msg_nxt.data = msi_data_r;
		// A new event beats a simultaneous clear so no interrupt is lost.
		intx_nxt = !msi_en_nxt && ((irq_event && !msi_en_r) || (intx_r && !irq_clear)); // RULE_01
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msi_en_r <= msi_vpd_pkg::RST_MSI_EN;
			mme_r <= msi_vpd_pkg::RST_MME;
			msi_addr_r <= msi_vpd_pkg::RST_MSI_ADDR;
			msi_uaddr_r <= msi_vpd_pkg::RST_MSI_UADDR;
			msi_data_r <= msi_vpd_pkg::RST_MSI_DATA;
			intx_r <= 1'b0;
			msi_msg_r <= '0;
			vpd_addr_r <= msi_vpd_pkg::RST_VPD_ADDR;
			vpd_we_r <= msi_vpd_pkg::RST_VPD_WE;
			vpd_op_r <= msi_vpd_pkg::RST_VPD_OP;
			product_data_value_r <= msi_vpd_pkg::RST_PRODUCT_DATA_VALUE;
			vpd_state_r <= msi_vpd_pkg::VPD_IDLE;
			ee_req_r <= '0;
		end else if (ce) begin
			msi_en_r <= msi_en_nxt;
			mme_r <= mme_nxt;
			msi_addr_r <= msi_addr_nxt;
			msi_uaddr_r <= msi_uaddr_nxt;
			msi_data_r <= msi_data_nxt;
			intx_r <= intx_nxt;
			msi_msg_r <= msi_msg_nxt;
			vpd_addr_r <= vpd_addr_nxt;
			vpd_we_r <= vpd_we_nxt;
			vpd_op_r <= vpd_op_nxt;
			product_data_value_r <= product_data_value_nxt;
			vpd_state_r <= vpd_state_nxt;
			ee_req_r <= ee_req_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign intx_assert = intx_r;
	assign msi_msg = msi_msg_r;
	assign ee_req = ee_req_r;

	// ***********************************************************
	// Checks
	// ***********************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	no_intx_msi_a: assert property (msi_en_r |-> !intx_r) // RULE_01
		else $error("legacy interrupt asserted while messages are enabled");
	msg_gated_a: assert property (msi_msg_r.valid |-> $past(msi_en_r)) // RULE_01
		else $error("interrupt message sent while disabled");
	msg_payload_a: assert property ((ce && irq_event && msi_en_r) |=> // RULE_19
		(msi_msg_r.valid && msi_msg_r.data == $past(msi_data_r)
		&& msi_msg_r.addr[1:0] == 2'b00))
		else $error("interrupt message missing or wrong payload");
	addr64_read_a: assert property ((rvalid_r && !IS_UPSTREAM // RULE_02
		&& rd_off_r == msi_vpd_pkg::OFF_MSI_CTRL) |-> rdata_r[23] && rdata_r[7:0] == 8'h05)
		else $error("message control header read wrong");
	addr_align_a: assert property ((rvalid_r // RULE_03
		&& rd_off_r == msi_vpd_pkg::OFF_MSI_ADDR) |-> rdata_r[1:0] == 2'b00)
		else $error("message address low bits not zero");
	absent_regs_a: assert property ((rvalid_r && IS_UPSTREAM // RULE_05
		&& rd_off_r == msi_vpd_pkg::OFF_MSI_ADDR) |-> rresp_r == msi_vpd_pkg::RESP_SLVERR)
		else $error("message register visible on upstream port");
	vpd_header_a: assert property ((rvalid_r && IS_UPSTREAM // RULE_07
		&& rd_off_r == msi_vpd_pkg::OFF_VPD_CTRL) |-> rdata_r[15:0] == 16'h6403)
		else $error("product data header read wrong");
	vendor_header_a: assert property ((rvalid_r // RULE_17
		&& rd_off_r == msi_vpd_pkg::OFF_VENDOR) |-> rdata_r == 32'h0034_b009)
		else $error("vendor capability header read wrong");
	busy_request_a: assert property ((vpd_state_r == msi_vpd_pkg::VPD_WAIT) // RULE_10
		|-> (ee_req_r.req && vpd_op_r == ee_req_r.write))
		else $error("table cycle flag or request inconsistent");
	read_done_a: assert property ((ce && vpd_state_r == msi_vpd_pkg::VPD_WAIT // RULE_12
		&& ee_ack && !ee_req_r.write) |=> (vpd_op_r && product_data_value_r == $past(ee_rdata)
		&& !ee_req_r.req))
		else $error("table read completion wrong");
	write_done_a: assert property ((ce && vpd_state_r == msi_vpd_pkg::VPD_WAIT // RULE_11
		&& ee_ack && ee_req_r.write) |=> (!vpd_op_r && !ee_req_r.req))
		else $error("table write completion wrong");
	write_gate_a: assert property ((ee_req_r.req && ee_req_r.write) |-> vpd_we_r) // RULE_09
		else $error("table write issued without write enable");

	msg_sent_c: cover property (msi_msg_r.valid);
	vpd_read_c: cover property (vpd_state_r == msi_vpd_pkg::VPD_WAIT && ee_ack
		&& !ee_req_r.write);
	vpd_write_c: cover property (vpd_state_r == msi_vpd_pkg::VPD_WAIT && ee_ack
		&& ee_req_r.write);
	slverr_c: cover property (rvalid_r && rresp_r == msi_vpd_pkg::RESP_SLVERR);

endmodule

//--- tb/eeprom_model.sv
/*
 * Behavioural table memory that answers the bank's table requests.
 * Assumes the level request and one-cycle acknowledge of the bank's table port.
 */
`timescale 1ns/10ps
module eeprom_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire msi_vpd_pkg::eeprom_req_t ee_req,
	input wire logic [3:0] lat,
	output logic ee_ack,
	output logic [31:0] ee_rdata
);
	logic [31:0] mem [64];
	logic [3:0] cnt;

	// Read data toggles in every cycle out of reset but a read acknowledge, so a capture at the wrong edge shows.
	always @(posedge aclk) begin
		ee_ack <= 1'b0;
		ee_rdata <= ~ee_rdata;
		if (!aresetn) begin
			cnt <= 4'h0;
			ee_rdata <= 32'h0000_0000;
			for (int i = 0; i < 64; i++) begin
				mem[i] <= 32'ha5a5_0000 + 32'(i);
			end
		end else if (ee_req.req && !ee_ack) begin
			cnt <= cnt + 4'h1;
			if (cnt >= lat) begin
				cnt <= 4'h0;
				ee_ack <= 1'b1;
				if (ee_req.write) begin
					mem[ee_req.addr] <= ee_req.wdata;
				end else begin
					ee_rdata <= mem[ee_req.addr];
				end
			end
		end
	end
endmodule

//--- tb/msi_vpd_capability_regs_tb_top.sv
/*
 * Bench for the capability register bank: a downstream and an upstream instance
 * share one AXI4-Lite master, each with its own table model.
 * Assumes the package, the bank and the table model are compiled first.
 */
`timescale 1ns/10ps
module msi_vpd_capability_regs_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, sel = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
	logic irq_event = 1'b0, irq_clear = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0, lat = 4'h4;
	logic awready [2], wready [2], bvalid [2], arready [2], rvalid [2], intx [2], ack [2];
	logic [1:0] bresp [2], rresp [2];
	logic [31:0] rdata [2], erd [2];
	msi_vpd_pkg::msi_msg_t msg [2];
	msi_vpd_pkg::eeprom_req_t req [2];
	int bad_count = 0, n_compared = 0;

	always #2.5 aclk = ~aclk;

	for (genvar i = 0; i < 2; i++) begin : g_port
		msi_vpd_regs #(.IS_UPSTREAM(i == 1)) u_msi_vpd_regs (
			.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
			.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid && sel == 1'(i)),
			.s_axi_awready(awready[i]), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
			.s_axi_wvalid(wvalid && sel == 1'(i)), .s_axi_wready(wready[i]),
			.s_axi_bresp(bresp[i]), .s_axi_bvalid(bvalid[i]), .s_axi_bready(bready),
			.s_axi_araddr(araddr), .s_axi_arvalid(arvalid && sel == 1'(i)),
			.s_axi_arready(arready[i]), .s_axi_rdata(rdata[i]), .s_axi_rresp(rresp[i]),
			.s_axi_rvalid(rvalid[i]), .s_axi_rready(rready), .irq_event(irq_event),
			.irq_clear(irq_clear), .intx_assert(intx[i]), .msi_msg(msg[i]),
			.ee_req(req[i]), .ee_ack(ack[i]), .ee_rdata(erd[i]));
		eeprom_model u_eeprom_model (.aclk(aclk), .aresetn(aresetn), .ee_req(req[i]),
			.lat(lat), .ee_ack(ack[i]), .ee_rdata(erd[i]));
	end

	// ***********************************************************
	// Bus and compare helpers
	// ***********************************************************
	task automatic chk(input string nm, input logic [80:0] got, input logic [80:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic p, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		sel <= p; awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (awready[p] !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (wready[p] !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		// Bready stays high between writes so back-to-back calls never drive it twice at once.
		do @(posedge aclk); while (bvalid[p] !== 1'b1);
		chk("bresp", bresp[p], er);
	endtask

	task automatic rd(input logic p, input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		sel <= p; araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge aclk); while (arready[p] !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid[p] !== 1'b1) @(posedge aclk);
		d = rdata[p];
		r = rresp[p];
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rdc(input logic p, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(p, a, d, r);
		chk("rdata", d, e);
		chk("rresp", r, er);
	endtask

	// Polls the operation flag; the watchdog bounds a flag that never moves.
	task automatic flag_wait(input logic want);
		logic [31:0] d;
		logic [1:0] r;
		do rd(1'b1, 8'h5c, d, r); while (d[31] !== want);
	endtask

	// ***********************************************************
	// Scenarios
	// ***********************************************************
	task automatic t_reset_values();
		rdc(1'b0, 8'h4c, 32'h0080_6405, 2'h0);
		rdc(1'b0, 8'h50, 32'h0000_0000, 2'h0);
		rdc(1'b0, 8'h54, 32'h0000_0000, 2'h0);
		rdc(1'b0, 8'h58, 32'h0000_0000, 2'h0);
		rdc(1'b0, 8'h64, 32'h0034_b009, 2'h0);
		rdc(1'b1, 8'h5c, 32'h0000_6403, 2'h0);
		rdc(1'b1, 8'h60, 32'h0000_0000, 2'h0);
		rdc(1'b1, 8'h64, 32'h0034_b009, 2'h0);
	endtask

	task automatic t_absent();
		rdc(1'b1, 8'h4c, 32'h0, 2'h2);
		wr(1'b1, 8'h50, 32'h1111_1111, 4'hf, 2'h2);
		rdc(1'b0, 8'h5c, 32'h0, 2'h2);
		rdc(1'b0, 8'h60, 32'h0, 2'h2);
	endtask

	task automatic t_message();
		wr(1'b0, 8'h50, 32'hffff_ffff, 4'hf, 2'h0);
		rdc(1'b0, 8'h50, 32'hffff_fffc, 2'h0);
		wr(1'b0, 8'h54, 32'h1234_5678, 4'hf, 2'h0);
		rdc(1'b0, 8'h54, 32'h1234_5678, 2'h0);
		wr(1'b0, 8'h58, 32'habcd_9876, 4'hf, 2'h0);
		rdc(1'b0, 8'h58, 32'h0000_9876, 2'h0);
		// Legacy interrupt first, while messages are still off.
		irq_event <= 1'b1;
		@(posedge aclk);
		irq_event <= 1'b0;
		@(posedge aclk);
		chk("msg_off", msg[0].valid, 1'b0);
		chk("intx_on", intx[0], 1'b1);
		irq_clear <= 1'b1;
		@(posedge aclk);
		irq_clear <= 1'b0;
		@(posedge aclk);
		chk("intx_clr", intx[0], 1'b0);
		wr(1'b0, 8'h4c, 32'h0031_0000, 4'h4, 2'h0);
		rdc(1'b0, 8'h4c, 32'h00b1_6405, 2'h0);
		irq_event <= 1'b1;
		@(posedge aclk);
		irq_event <= 1'b0;
		@(posedge aclk);
		chk("msg", msg[0], {1'b1, 64'h1234_5678_ffff_fffc, 16'h9876});
		chk("intx_en", intx[0], 1'b0);
		@(posedge aclk);
		chk("msg_pulse", msg[0].valid, 1'b0);
	endtask

	task automatic t_table();
		lat <= 4'h6;
		wr(1'b1, 8'h5c, 32'h0014_0000, 4'hc, 2'h0);
		rdc(1'b1, 8'h5c, 32'h0014_6403, 2'h0);
		flag_wait(1'b1);
		rdc(1'b1, 8'h60, 32'ha5a5_0005, 2'h0);
		wr(1'b1, 8'h5c, 32'h8024_0000, 4'hc, 2'h0);
		chk("no_req", req[1].req, 1'b0);
		rdc(1'b1, 8'h5c, 32'h0024_6403, 2'h0);
		lat <= 4'h0;
		wr(1'b1, 8'h60, 32'h1357_9bdf, 4'hf, 2'h0);
		wr(1'b1, 8'h5c, 32'hc024_0000, 4'hc, 2'h0);
		chk("wr_req", req[1], {2'b11, 6'd9, 32'h1357_9bdf});
		flag_wait(1'b0);
		wr(1'b1, 8'h60, 32'h0000_0000, 4'hf, 2'h0);
		wr(1'b1, 8'h5c, 32'h0024_0000, 4'hc, 2'h0);
		flag_wait(1'b1);
		rdc(1'b1, 8'h60, 32'h1357_9bdf, 2'h0);
	endtask

	// ***********************************************************
	// Sequence, watchdog and verdict
	// ***********************************************************
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset_values();
		t_absent();
		t_message();
		t_table();
		end_of_test();
	end

	initial begin
		#50us;
		bad_count++;
		end_of_test();
	end
endmodule
